// >>> logic/pms_mgmt_slave.sv
// Purpose: Management serial slave with interrupt output
// Assumes: Management clock far slower than clk, sampled as a pin
// Notes: Register contents beyond the control bits are plain storage
//
// Function
// - Strapped 3-bit station address, upper bits zero
// - Frame: 32 ones, start 01, opcode
// - Turnaround, device drives 0 on reads
// - Five-bit address selects 32 registers
// - Broadcast enable also accepts station address 0
// - Broadcast writes update the register here too
// - Drive select: 0 open-drain, 1 push-pull
// - Interrupt output flags register status changes
// - Upper eight bits enable each condition
// - Lower eight bits latch occurred conditions
// - Reading interrupt register clears all flags
// - Interrupt active low unless polarity inverted
`timescale 1ns/1ns
module pms_mgmt_slave
  import pms_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Straps
  input wire logic [pms_pkg::STN_AW-1:0] strap_station_addr,
  // Management link
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  // Interrupt conditions and pin
  input wire logic [pms_pkg::IRQ_N-1:0] irq_event,
  output logic irq_out
);
  import pms_pkg::*;

  logic mdc_s1_reg, mdc_s2_reg, mdc_d_reg;
  logic dio_s1_reg, dio_s2_reg;
  logic [STN_AW-1:0] strap_s1_reg, strap_s2_reg, stn_addr_reg;
  logic rise;
  pms_state_t state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [DATA_W-1:0] shift_reg;
  logic [1:0] op_reg;
  logic [REG_AW-1:0] addr_reg;
  logic [DATA_W-1:0] rd_shift_reg;
  logic drv_en_reg, drv_val_reg;
  logic bcast_en_reg, push_pull_reg, irq_pol_reg;
  logic [IRQ_N-1:0] irq_en_reg, irq_flag_reg;
  logic wr_pulse, irq_rd_clear, stn_match;
  logic [DATA_W-1:0] mem_rdata, wr_word;
  logic [STN_AW+1:0] stn_field;

  // Pin synchronisers
  always_ff @(posedge clk) begin
    mdc_s1_reg <= mdc;
    mdc_s2_reg <= mdc_s1_reg;
    mdc_d_reg <= mdc_s2_reg;
    dio_s1_reg <= mdio_in;
    dio_s2_reg <= dio_s1_reg;
    strap_s1_reg <= strap_station_addr;
    strap_s2_reg <= strap_s1_reg;
  end

  assign rise = mdc_s2_reg & ~mdc_d_reg;

  // Station address is caught while reset is held
  always_ff @(posedge clk) begin
    if (reset) begin
      stn_addr_reg <= strap_s2_reg;
    end
  end

  assign stn_field = {shift_reg[STN_AW+1:0]};
  assign stn_match = (stn_field[STN_AW+1:STN_AW] == STN_HIGH) &&
    ((stn_field[STN_AW-1:0] == stn_addr_reg) ||
     (bcast_en_reg && stn_field[STN_AW-1:0] == BCAST_ADDR));

  assign wr_word = {shift_reg[DATA_W-2:0], dio_s2_reg};
  assign wr_pulse = rise && state_reg == PMS_WR &&
    cnt_reg == CNT_W'(DATA_W - 1);
  assign irq_rd_clear = rise && state_reg == PMS_TA &&
    op_reg == OP_READ && addr_reg == IRQ_REG_ADDR;

  // Frame decoder
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= PMS_PRE;
      cnt_reg <= '0;
      shift_reg <= '0;
      op_reg <= '0;
      addr_reg <= '0;
    end else if (rise) begin
      shift_reg <= wr_word;
      case (state_reg)
        PMS_PRE: begin
          if (dio_s2_reg) begin
            if (cnt_reg != CNT_W'(PRE_ONES)) begin
              cnt_reg <= cnt_reg + 1'b1;
            end
          end else begin
            cnt_reg <= '0;
            if (cnt_reg == CNT_W'(PRE_ONES)) begin
              state_reg <= PMS_START;
            end
          end
        end
        PMS_START: begin
          cnt_reg <= '0;
          state_reg <= dio_s2_reg ? PMS_OP : PMS_PRE;
        end
        PMS_OP: begin
          if (cnt_reg == CNT_W'(1)) begin
            cnt_reg <= '0;
            op_reg <= wr_word[1:0];
            if (wr_word[1:0] == OP_READ || wr_word[1:0] == OP_WRITE) begin
              state_reg <= PMS_STN;
            end else begin
              state_reg <= PMS_PRE;
            end
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        PMS_STN: begin
          if (cnt_reg == CNT_W'(STN_AW + 1)) begin
            cnt_reg <= '0;
            state_reg <= PMS_REG;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        PMS_REG: begin
          if (cnt_reg == CNT_W'(REG_AW - 1)) begin
            cnt_reg <= '0;
            addr_reg <= wr_word[REG_AW-1:0];
            // Shifter now holds register bits; the station verdict was
            // folded into op_reg on the first register bit
            state_reg <= (op_reg != 2'h0) ? PMS_TA : PMS_PRE;
          end else begin
            if (cnt_reg == '0) begin
              // Station field complete in the shifter here
              if (!stn_match) begin
                op_reg <= 2'h0;
              end
            end
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        PMS_TA: begin
          if (op_reg == OP_READ) begin
            cnt_reg <= '0;
            state_reg <= PMS_RD;
          end else if (cnt_reg == CNT_W'(1)) begin
            cnt_reg <= '0;
            state_reg <= PMS_WR;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        PMS_WR: begin
          if (cnt_reg == CNT_W'(DATA_W - 1)) begin
            cnt_reg <= '0;
            state_reg <= PMS_PRE;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        PMS_RD: begin
          if (cnt_reg == CNT_W'(DATA_W)) begin
            cnt_reg <= '0;
            state_reg <= PMS_PRE;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        default: begin
          cnt_reg <= '0;
          state_reg <= PMS_PRE;
        end
      endcase
    end
  end

  // Read data driver, changes just after rising edges
  always_ff @(posedge clk) begin
    if (reset) begin
      drv_en_reg <= 1'b0;
      drv_val_reg <= 1'b0;
      rd_shift_reg <= '0;
    end else if (rise) begin
      if (state_reg == PMS_TA && op_reg == OP_READ) begin
        drv_en_reg <= 1'b1;
        drv_val_reg <= 1'b0;
        rd_shift_reg <= (addr_reg == IRQ_REG_ADDR) ?
          {irq_en_reg, irq_flag_reg} : mem_rdata;
      end else if (state_reg == PMS_RD && cnt_reg != CNT_W'(DATA_W)) begin
        drv_val_reg <= rd_shift_reg[DATA_W-1];
        rd_shift_reg <= {rd_shift_reg[DATA_W-2:0], 1'b0};
      end else begin
        drv_en_reg <= 1'b0;
        drv_val_reg <= 1'b0;
      end
    end
  end

  // Pin stage: open-drain only pulls low
  always_ff @(posedge clk) begin
    if (reset) begin
      mdio_oe <= 1'b0;
      mdio_out <= 1'b0;
    end else begin
      mdio_oe <= drv_en_reg && (push_pull_reg || !drv_val_reg);
      mdio_out <= push_pull_reg && drv_val_reg;
    end
  end

  // Control bits mirrored from register writes
  always_ff @(posedge clk) begin
    if (reset) begin
      bcast_en_reg <= 1'b0;
      push_pull_reg <= 1'b0;
      irq_pol_reg <= 1'b0;
      irq_en_reg <= IRQ_EN_RESET;
    end else if (wr_pulse) begin
      if (addr_reg == COMMON_CTRL_ADDR) begin
        bcast_en_reg <= wr_word[BCAST_EN_BIT];
      end
      if (addr_reg == DRIVE_CTRL_ADDR) begin
        push_pull_reg <= wr_word[PUSH_PULL_BIT];
      end
      if (addr_reg == IRQ_POL_ADDR) begin
        irq_pol_reg <= wr_word[IRQ_POL_BIT];
      end
      if (addr_reg == IRQ_REG_ADDR) begin
        irq_en_reg <= wr_word[DATA_W-1:IRQ_EN_LSB];
      end
    end
  end

  // Sticky flags; a new event wins over the read clear
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_flag_reg <= IRQ_FLAG_RESET;
    end else begin
      irq_flag_reg <= (irq_rd_clear ? IRQ_FLAG_RESET : irq_flag_reg) |
        irq_event;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_out <= 1'b1;
    end else begin
      irq_out <= (|(irq_flag_reg & irq_en_reg)) ~^ irq_pol_reg;
    end
  end

  pms_regmem #(
    .WIDTH(DATA_W),
    .AW(REG_AW)
  ) u_regmem (
    .clk(clk),
    .reset(reset),
    .wr_en(wr_pulse),
    .wr_addr(addr_reg),
    .wr_data(wr_word),
    .rd_addr(addr_reg),
    .rd_data(mem_rdata)
  );
endmodule

// >>> logic/pms_pkg.sv
// Purpose: Shared constants of the management serial slave
// Assumes: 16-bit registers, 32 directly addressed entries
// Notes: Control register offsets and bit positions are local choices
package pms_pkg;
  localparam int DATA_W = 16;
  localparam int REG_AW = 5;
  localparam int STN_AW = 3;
  localparam int PRE_ONES = 32;
  localparam int CNT_W = 6;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] STN_HIGH = 2'h0;
  localparam logic [STN_AW-1:0] BCAST_ADDR = 3'h0;
  // Register offsets
  localparam logic [REG_AW-1:0] IRQ_REG_ADDR = 5'h1B;
  localparam logic [REG_AW-1:0] COMMON_CTRL_ADDR = 5'h1C;
  localparam logic [REG_AW-1:0] DRIVE_CTRL_ADDR = 5'h1D;
  localparam logic [REG_AW-1:0] IRQ_POL_ADDR = 5'h1F;
  // Field positions
  localparam int BCAST_EN_BIT = 0;
  localparam int PUSH_PULL_BIT = 1;
  localparam int IRQ_POL_BIT = 14;
  localparam int IRQ_EN_LSB = 8;
  localparam int IRQ_N = 8;
  // Reset values
  localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
  localparam logic [IRQ_N-1:0] IRQ_EN_RESET = 8'h00;
  localparam logic [IRQ_N-1:0] IRQ_FLAG_RESET = 8'h00;
  typedef enum logic [2:0] {
    PMS_PRE, PMS_START, PMS_OP, PMS_STN, PMS_REG, PMS_TA, PMS_WR, PMS_RD
  } pms_state_t;
endpackage

// >>> logic/pms_regmem.sv
// Purpose: Register store with registered read data
// Assumes: Single write port, read address sampled every clock
// Notes: Synchronous reset clears every entry
`timescale 1ns/1ns
module pms_regmem #(
  parameter int WIDTH = 16,
  parameter int AW = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read port
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [2**AW];

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < 2**AW; i++) begin
        mem[i] <= '0;
      end
    end else if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// >>> tb/pms_sva.sv
// Purpose: Port checker for the management serial slave
// Assumes: mdc far slower than clk
// Notes: since_reg counts clk cycles from a raw mdc rise
`timescale 1ns/1ns
module pms_sva
  import pms_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Straps and link
  input wire logic [pms_pkg::STN_AW-1:0] strap_station_addr,
  input wire logic mdc,
  input wire logic mdio_in,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  // Interrupt
  input wire logic [pms_pkg::IRQ_N-1:0] irq_event,
  input wire logic irq_out
);
  logic mdc_reg;
  logic [7:0] since_reg;
  always_ff @(posedge clk) begin
    mdc_reg <= mdc;
  end
  always_ff @(posedge clk) begin
    if (reset) since_reg <= 8'hFF;
    else if (mdc && !mdc_reg) since_reg <= 8'h00;
    else if (since_reg != 8'hFF) since_reg <= since_reg + 8'h01;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  AST_RST_OE: assert property ($fell(reset) |-> !mdio_oe)
    else $error("line driven after reset");
  AST_RST_IRQ: assert property ($fell(reset) |-> irq_out)
    else $error("interrupt active after reset");
  AST_OE_RISE: assert property ($rose(mdio_oe) |-> since_reg <= 8'h08)
    else $error("drive start not tied to mdc rise");
  AST_OE_FALL: assert property ($fell(mdio_oe) |-> since_reg <= 8'h08)
    else $error("release not tied to mdc rise");
  AST_OUT_CHG: assert property ($changed(mdio_out) |-> since_reg <= 8'h08)
    else $error("data change not tied to mdc rise");
  AST_OE_IDLE: assert property (mdio_oe |-> since_reg <= 8'h14)
    else $error("line driven while link idle");
  AST_OE_HOLD: assert property ($rose(mdio_oe) |=> mdio_oe [*7])
    else $error("driven bit too short");
  AST_IRQ_CAUSE: assert property ($changed(irq_out) |->
    $past(irq_event, 2) != 8'h00 || since_reg <= 8'h0E)
    else $error("interrupt changed without cause");
endmodule
bind pms_mgmt_slave pms_sva chk (.clk(clk), .reset(reset),
  .strap_station_addr(strap_station_addr), .mdc(mdc), .mdio_in(mdio_in),
  .mdio_out(mdio_out), .mdio_oe(mdio_oe), .irq_event(irq_event),
  .irq_out(irq_out));

// >>> tb/pms_ctrl_model.sv
// Purpose: Station controller model driving mdc and the data line
// Assumes: Pull-up on the data line, mdc low between frames
// Notes: Read result is the second turnaround bit and 16 data bits
`timescale 1ns/1ns
module pms_ctrl_model (
  // Link
  output logic mdc,
  output logic line,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  // Read result
  output logic rd_stb,
  output logic [16:0] rd_data
);
  logic ctl_drv;
  logic ctl_bit;
  // Wired line with pull-up
  assign line = (!ctl_drv | ctl_bit) & (!mdio_oe | mdio_out);
  initial begin
    mdc = 1'b0;
    ctl_drv = 1'b0;
    ctl_bit = 1'b0;
    rd_stb = 1'b0;
    rd_data = 17'h00000;
  end
  task automatic clk_bit(input logic d, input logic en, output logic s);
    ctl_drv = en;
    ctl_bit = d;
    #62 mdc = 1'b1;
    s = line;
    #63 mdc = 1'b0;
  endtask
  task automatic frame(input logic [13:0] hd, input logic [15:0] wd);
    logic s;
    logic rd;
    logic [17:0] v;
    logic [17:0] r;
    rd = (hd[11:10] == 2'h2);
    v = {2'h2, wd};
    for (int i = 0; i < 32; i++) clk_bit(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) clk_bit(hd[i], 1'b1, s);
    // Reads release turnaround and data
    for (int i = 17; i >= 0; i--) begin
      clk_bit(v[i], !rd, s);
      r[i] = s;
    end
    ctl_drv = 1'b0;
    if (rd) begin
      rd_data = r[16:0];
      rd_stb = 1'b1;
      #1 rd_stb = 1'b0;
    end
  endtask
endmodule

// >>> tb/phy_mgmt_serial_with_irq_tb.sv
// Purpose: Self-checking bench of the management serial slave
// Assumes: Controller model on the link, pull-up on the line
// Notes: Read results compared from a queue by a monitor
`timescale 1ns/1ns
module phy_mgmt_serial_with_irq_tb;
  import pms_pkg::*;
  logic clk, reset, mdc, line, mdio_out, mdio_oe, irq_out, rd_stb, saw_hi;
  logic [2:0] stn;
  logic [7:0] ev;
  logic [16:0] rd_data;
  logic [16:0] exp_q[$];
  logic [15:0] d;
  logic [4:0] ra;
  int fails, n_compared;
  always #4 clk = ~clk;
  pms_mgmt_slave uut (.clk(clk), .reset(reset), .strap_station_addr(stn),
    .mdc(mdc), .mdio_in(line), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .irq_event(ev), .irq_out(irq_out));
  pms_ctrl_model ctl (.mdc(mdc), .line(line), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .rd_stb(rd_stb), .rd_data(rd_data));
  always @(posedge clk) begin
    if (reset) saw_hi <= 1'b0;
    else if (mdio_oe && mdio_out) saw_hi <= 1'b1;
  end
  task close_out;
    if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk_rd(input logic [16:0] e, input logic [16:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("Error rd_data exp %h got %h", e, g);
    end
  endtask
  task chk_bit(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("Error %s exp %b got %b", nm, e, g);
    end
  endtask
  always @(posedge rd_stb) chk_rd(exp_q.pop_front(), rd_data);
  task wr(input logic [2:0] a, input logic [4:0] r, input logic [15:0] v);
    ctl.frame({2'h1, OP_WRITE, STN_HIGH, a, r}, v);
  endtask
  task rd(input logic [2:0] a, input logic [4:0] r, input logic [15:0] v);
    exp_q.push_back({1'b0, v});
    ctl.frame({2'h1, OP_READ, STN_HIGH, a, r}, 16'h0000);
  endtask
  task pulse(input logic [7:0] e);
    @(posedge clk);
    #1 ev = e;
    @(posedge clk);
    #1 ev = 8'h00;
    repeat (4) @(posedge clk);
    #1;
  endtask
  initial begin
    #400000 fails++;
    close_out();
  end
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    ev = 8'h00;
    fails = 0;
    n_compared = 0;
    void'($urandom(28799));
    stn = 3'($urandom_range(7, 1));
    ra = 5'($urandom_range(26, 0));
    d = 16'($urandom);
    repeat (4) @(posedge clk);
    #1 reset = 1'b0;
    repeat (4) @(posedge clk);
    rd(stn, IRQ_REG_ADDR, 16'h0000);
    wr(stn, ra, d);
    rd(stn, ra, d);
    wr(stn + 3'h1, ra, ~d);
    wr(BCAST_ADDR, ra, ~d);
    ctl.frame({2'h1, OP_WRITE, 2'h1, stn, ra}, ~d);
    ctl.frame({2'h0, OP_WRITE, STN_HIGH, stn, ra}, ~d);
    ctl.frame({2'h1, 2'h3, STN_HIGH, stn, ra}, ~d);
    rd(stn, ra, d);
    wr(stn, COMMON_CTRL_ADDR, 16'h0001);
    wr(BCAST_ADDR, ra, ~d);
    rd(BCAST_ADDR, ra, ~d);
    chk_bit("saw_hi", 1'b0, saw_hi);
    wr(stn, DRIVE_CTRL_ADDR, 16'h0002);
    rd(stn, DRIVE_CTRL_ADDR, 16'h0002);
    chk_bit("saw_hi", 1'b1, saw_hi);
    chk_bit("irq_out", 1'b1, irq_out);
    wr(stn, IRQ_REG_ADDR, 16'h01FF);
    pulse(8'h02);
    chk_bit("irq_out", 1'b1, irq_out);
    pulse(8'h01);
    chk_bit("irq_out", 1'b0, irq_out);
    rd(stn, IRQ_REG_ADDR, 16'h0103);
    chk_bit("irq_out", 1'b1, irq_out);
    rd(stn, IRQ_REG_ADDR, 16'h0100);
    wr(stn, IRQ_POL_ADDR, 16'h4000);
    repeat (20) @(posedge clk);
    #1 chk_bit("irq_out", 1'b0, irq_out);
    pulse(8'h01);
    chk_bit("irq_out", 1'b1, irq_out);
    repeat (20) @(posedge clk);
    close_out();
  end
endmodule
